// ### logic/trg_pkg.sv
`default_nettype none
package trg_pkg;
	// ----------------------------------------
	// object indices
	// ----------------------------------------
	localparam logic [15:0] IDX_TERM_SEL = 16'h427f;
	localparam logic [15:0] IDX_REG_BASE = 16'h4280;
	localparam logic [15:0] IDX_REG_LAST = 16'h4287;
	// ----------------------------------------
	// terminal registers
	// ----------------------------------------
	localparam logic [7:0] REG_CODE = 8'h1f;
	localparam logic [7:0] REG_USER_LO = 8'h20;
	localparam logic [7:0] REG_USER_HI = 8'h2f;
	localparam logic [7:0] REGS_PER_PAGE = 8'h40;
	localparam logic [15:0] CODE_UNLOCK = 16'h1235;
	localparam logic [15:0] CODE_CLOSED = 16'h0000;
	localparam logic [15:0] TERM_NONE = 16'h0000;
	// ----------------------------------------
	// sizes and reset values
	// ----------------------------------------
	localparam int TERM_MAX = 64;
	localparam int CHAN_W = 2;
	localparam logic [15:0] SEL_RST = 16'h0000;
	// ----------------------------------------
	// controller states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_XFER = 3'b010,
		ST_RESP = 3'b100
	} trg_state_e;
endpackage
`default_nettype wire

// ### logic/trg_obj_map.sv
`default_nettype none
module trg_obj_map (
	input wire logic [15:0] obj_index,
	input wire logic [7:0] obj_sub,
	output logic is_sel,
	output logic is_reg,
	output logic map_ok,
	output logic [1:0] chan,
	output logic [7:0] reg_num
);
	// ----------------------------------------
	// index and sub-index mapping
	// ----------------------------------------
	logic hi_page;
	logic [7:0] sub_m1;
	always_comb begin
		is_sel = (obj_index == trg_pkg::IDX_TERM_SEL);
		is_reg = (obj_index >= trg_pkg::IDX_REG_BASE) && (obj_index <= trg_pkg::IDX_REG_LAST);
		chan = obj_index[2:1];
		hi_page = obj_index[0];
		sub_m1 = obj_sub - 8'h01;
		// low page holds 0 to 63 only
		if (hi_page) begin
			reg_num = 8'(sub_m1 + trg_pkg::REGS_PER_PAGE);
			map_ok = (obj_sub != 8'h00) && (obj_sub <= 8'hc0);
		end else begin
			reg_num = sub_m1;
			map_ok = (obj_sub != 8'h00) && (obj_sub <= trg_pkg::REGS_PER_PAGE);
		end
	end
endmodule // trg_obj_map
`default_nettype wire

// ### logic/trg_gateway.sv
`default_nettype none
// Operation
// - A 2-byte write to sub-index 0 of the select object picks the terminal for later accesses.
// - Terminal 1 is the first one after the coupler, counting up in physical order.
// - Writing zero to the select object drops the selection, done by the master per terminal.
// - Each sub-index reaches the terminal register numbered sub-index minus one, plus 64 on an odd index.
// - Channel n uses index 0x4280+2n for registers 0-63 and the next odd index above 63.
// - At most four channels or pages per terminal, each normally registers 0 to 63.
// - Registers 32 to 47 change only while 0x1235 stands in register 31; the code takes the code word from channel 0 low page only, for every channel.
// - Returning register 31 to zero commits the user parameters; the master must do it.
// - Entries go one at a time, each confirmed before the next may start.
// - Every received value is written to the terminal without comparing to the old one; the code drops locked user writes and aborted requests.
// - Register writes are taken in startup and in normal operation alike.
// - A missing terminal or one without register access gets an abort answer.
module trg_gateway (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [15:0] req_index,
	input wire logic [7:0] req_sub,
	input wire logic [15:0] req_data,
	output logic resp_valid,
	output logic resp_abort,
	input wire logic [15:0] term_count,
	input wire logic [trg_pkg::TERM_MAX-1:0] term_regcap,
	output logic tb_req,
	output logic [15:0] tb_term,
	output logic [1:0] tb_chan,
	output logic [7:0] tb_reg,
	output logic [15:0] tb_data,
	input wire logic tb_done,
	input wire logic tb_fail,
	output logic user_commit,
	output logic [15:0] term_sel,
	output logic unlocked
);
	// ----------------------------------------
	// request decode
	// ----------------------------------------
	logic is_sel;
	logic is_reg;
	logic map_ok;
	logic [1:0] m_chan;
	logic [7:0] m_reg;
	trg_obj_map u_map (
		.obj_index(req_index),
		.obj_sub(req_sub),
		.is_sel(is_sel),
		.is_reg(is_reg),
		.map_ok(map_ok),
		.chan(m_chan),
		.reg_num(m_reg)
	);

	// ----------------------------------------
	// state
	// ----------------------------------------
	trg_pkg::trg_state_e state_r, state_nxt;
	logic [15:0] sel_r, sel_nxt;
	logic unlock_r, unlock_nxt;
	logic tb_req_r, tb_req_nxt;
	logic [1:0] chan_r, chan_nxt;
	logic [7:0] reg_r, reg_nxt;
	logic [15:0] data_r, data_nxt;
	logic resp_v_r, resp_v_nxt;
	logic abort_r, abort_nxt;
	logic commit_r, commit_nxt;
	logic code_r, code_nxt;
	logic term_ok;
	logic [5:0] cap_idx;
	logic protected_reg;
	logic code_reg;

	always_comb begin
		// terminal n sits at bit n-1
		cap_idx = sel_r[5:0] - 6'h01;
		term_ok = (sel_r != trg_pkg::TERM_NONE) && (sel_r <= term_count)
			&& (sel_r <= 16'(trg_pkg::TERM_MAX)) && term_regcap[cap_idx];
		protected_reg = (m_reg >= trg_pkg::REG_USER_LO) && (m_reg <= trg_pkg::REG_USER_HI);
		code_reg = (m_reg == trg_pkg::REG_CODE);
	end

	// ----------------------------------------
	// code word target
	// ----------------------------------------
	// decided at take, so the transfer state needs no page compare
	always_comb begin
		code_nxt = code_r;
		if (state_r == trg_pkg::ST_IDLE && req_valid) begin
			code_nxt = code_reg && (m_chan == 2'h0) && !req_index[0];
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			code_r <= 1'b0;
		end else begin
			code_r <= code_nxt;
		end
	end

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		sel_nxt = sel_r;
		unlock_nxt = unlock_r;
		tb_req_nxt = tb_req_r;
		chan_nxt = chan_r;
		reg_nxt = reg_r;
		data_nxt = data_r;
		resp_v_nxt = 1'b0;
		abort_nxt = abort_r;
		commit_nxt = 1'b0;
		case (state_r)
			trg_pkg::ST_IDLE: begin
				if (req_valid) begin
					state_nxt = trg_pkg::ST_RESP;
					resp_v_nxt = 1'b1;
					abort_nxt = 1'b1;
					if (is_sel) begin
						if (req_sub == 8'h00) begin
							sel_nxt = req_data;
							abort_nxt = 1'b0;
							// new or no terminal, lock again
							unlock_nxt = 1'b0;
						end
					end else if (is_reg && map_ok && term_ok) begin
						// locked user writes never reach terminal
						if (!(protected_reg && !unlock_r)) begin
							state_nxt = trg_pkg::ST_XFER;
							resp_v_nxt = 1'b0;
							tb_req_nxt = 1'b1;
							chan_nxt = m_chan;
							reg_nxt = m_reg;
							data_nxt = req_data;
						end
					end
				end
			end
			trg_pkg::ST_XFER: begin
				if (tb_done) begin
					tb_req_nxt = 1'b0;
					state_nxt = trg_pkg::ST_RESP;
					resp_v_nxt = 1'b1;
					abort_nxt = tb_fail;
					// code word only on page 0 low
					if (!tb_fail && code_r) begin
						unlock_nxt = (data_r == trg_pkg::CODE_UNLOCK);
						commit_nxt = unlock_r && (data_r == trg_pkg::CODE_CLOSED);
					end
				end
			end
			trg_pkg::ST_RESP: begin
				// one entry in flight at a time
				state_nxt = trg_pkg::ST_IDLE;
			end
			default: begin
				state_nxt = trg_pkg::ST_IDLE;
				tb_req_nxt = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= trg_pkg::ST_IDLE;
			sel_r <= trg_pkg::SEL_RST;
			unlock_r <= 1'b0;
			tb_req_r <= 1'b0;
			chan_r <= 2'h0;
			reg_r <= 8'h00;
			data_r <= 16'h0000;
			resp_v_r <= 1'b0;
			abort_r <= 1'b0;
			commit_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			sel_r <= sel_nxt;
			unlock_r <= unlock_nxt;
			tb_req_r <= tb_req_nxt;
			chan_r <= chan_nxt;
			reg_r <= reg_nxt;
			data_r <= data_nxt;
			resp_v_r <= resp_v_nxt;
			abort_r <= abort_nxt;
			commit_r <= commit_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// ready only when idle, so a second entry waits
	assign req_ready = (state_r == trg_pkg::ST_IDLE);
	assign resp_valid = resp_v_r;
	assign resp_abort = abort_r;
	assign tb_req = tb_req_r;
	assign tb_term = sel_r;
	assign tb_chan = chan_r;
	assign tb_reg = reg_r;
	assign tb_data = data_r;
	assign user_commit = commit_r;
	assign term_sel = sel_r;
	assign unlocked = unlock_r;
endmodule // trg_gateway
`default_nettype wire

// ### verif/trg_gateway_asserts.sv
`default_nettype none
module trg_gateway_asserts (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic [15:0] req_index,
	input wire logic [7:0] req_sub,
	input wire logic [15:0] req_data,
	input wire logic resp_valid,
	input wire logic resp_abort,
	input wire logic tb_req,
	input wire logic [1:0] tb_chan,
	input wire logic [7:0] tb_reg,
	input wire logic tb_done,
	input wire logic tb_fail,
	input wire logic user_commit,
	input wire logic [15:0] term_sel,
	input wire logic unlocked
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	logic take;
	assign take = req_valid && req_ready;
	// -------
	// checks
	// -------
	a_answer_pulse: assert property (resp_valid |=> !resp_valid && req_ready)
		else $error("answer not one cycle");
	a_xfer_hold: assert property (tb_req && !tb_done |=> tb_req && $stable(tb_reg) && !resp_valid)
		else $error("transfer dropped early");
	a_xfer_answer: assert property (tb_req && tb_done |=> resp_valid && resp_abort == $past(tb_fail))
		else $error("transfer answer wrong");
	a_select_take: assert property (take && req_index == 16'h427f && req_sub == 8'h00
		|=> resp_valid && !resp_abort && term_sel == $past(req_data))
		else $error("selection not taken");
	a_reg_map: assert property ($rose(tb_req) |-> tb_chan == $past(req_index[2:1])
		&& tb_reg == $past(req_sub) - 8'h01 + ($past(req_index[0]) ? 8'h40 : 8'h00))
		else $error("register mapping wrong");
	a_lock_refuse: assert property (take && req_index == 16'h4280 && req_sub > 8'h20
		&& req_sub < 8'h31 && !unlocked |=> resp_valid && resp_abort)
		else $error("locked write accepted");
	a_no_term: assert property (take && req_index[15:3] == 13'h0850 && term_sel == 16'h0000
		|=> resp_valid && resp_abort)
		else $error("no terminal yet accepted");
	a_commit_ok: assert property (user_commit |-> resp_valid && !resp_abort && !unlocked)
		else $error("commit without close");
	c_commit: cover property (user_commit);
	c_abort: cover property (resp_valid && resp_abort);
	c_fail: cover property (tb_req && tb_done && tb_fail);
endmodule // trg_gateway_asserts
bind trg_gateway trg_gateway_asserts i_chk (.core_clk, .rstn, .req_valid, .req_ready,
	.req_index, .req_sub, .req_data, .resp_valid, .resp_abort, .tb_req, .tb_chan, .tb_reg,
	.tb_done, .tb_fail, .user_commit, .term_sel, .unlocked);
`default_nettype wire

// ### verif/trg_tbus_model.sv
`default_nettype none
module trg_tbus_model (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic tb_req,
	input wire logic [3:0] lat,
	input wire logic fail_en,
	output logic tb_done,
	output var logic tb_fail
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_r;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) cnt_r <= 4'h0;
		else cnt_r <= (tb_req && !tb_done) ? cnt_r + 4'h1 : 4'h0;
	end
	assign tb_done = tb_req && cnt_r == lat;
	// fail only means something with done, so it wanders otherwise
	assign tb_fail = tb_done ? fail_en : cnt_r[0];
endmodule // trg_tbus_model
`default_nettype wire

// ### verif/trg_gateway_bench.sv
`default_nettype none
module trg_gateway_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, rstn, req_valid, tb_done, tb_fail, fail_en, req_ready, resp_valid;
	logic resp_abort, tb_req, user_commit, unlocked;
	logic [15:0] req_index, req_data, term_count, tb_term, tb_data, term_sel, seen_data, seen_term;
	logic [7:0] req_sub, tb_reg, seen_reg;
	logic [1:0] tb_chan, seen_chan;
	logic [63:0] term_regcap;
	logic [3:0] lat;
	int miscompares = 0, tests_run = 0, xfers = 0, commits = 0;
	trg_gateway i_dut (
		.core_clk(core_clk),
		.rstn(rstn),
		.req_valid(req_valid),
		.req_ready(req_ready),
		.req_index(req_index),
		.req_sub(req_sub),
		.req_data(req_data),
		.resp_valid(resp_valid),
		.resp_abort(resp_abort),
		.term_count(term_count),
		.term_regcap(term_regcap),
		.tb_req(tb_req),
		.tb_term(tb_term),
		.tb_chan(tb_chan),
		.tb_reg(tb_reg),
		.tb_data(tb_data),
		.tb_done(tb_done),
		.tb_fail(tb_fail),
		.user_commit(user_commit),
		.term_sel(term_sel),
		.unlocked(unlocked)
	);
	trg_tbus_model i_bus (
		.core_clk(core_clk),
		.rstn(rstn),
		.tb_req(tb_req),
		.lat(lat),
		.fail_en(fail_en),
		.tb_done(tb_done),
		.tb_fail(tb_fail)
	);
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (user_commit === 1'b1) commits++;
		if (tb_req === 1'b1 && tb_done === 1'b1) begin
			xfers++;
			{seen_reg, seen_chan, seen_data, seen_term} = {tb_reg, tb_chan, tb_data, tb_term};
		end
	end
	// --------
	// helpers
	// --------
	task automatic end_sim;
		$display("checks %0d errors %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e, input string nm);
		tests_run++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [15:0] d, input logic ab);
		int n;
		logic hit;
		@(posedge core_clk);
		{req_valid, req_index, req_sub, req_data} <= {1'b1, i, s, d};
		// hold the request until ready stands at an edge
		n = 0;
		do begin
			#1 hit = req_ready;
			@(posedge core_clk);
			n++;
		end while (hit !== 1'b1 && n < 60);
		req_valid <= 1'b0;
		#1 n = 0;
		while (resp_valid !== 1'b1 && n < 60) begin
			@(posedge core_clk);
			#1 n++;
		end
		if (hit !== 1'b1 || resp_valid !== 1'b1) begin
			miscompares++;
			end_sim;
		end else begin
			chk(resp_abort, ab, "abort");
		end
	endtask
	// ----------
	// scenarios
	// ----------
	task automatic t_code;
		int x;
		wr(16'h427f, 8'h00, 16'h0003, 1'b0);
		chk(term_sel, 16'h0003, "sel");
		x = xfers;
		wr(16'h4280, 8'h22, 16'h04d2, 1'b1);
		chk(16'(xfers - x), 16'h0000, "locked");
		wr(16'h4280, 8'h20, 16'h1235, 1'b0);
		chk(unlocked, 16'h0001, "unlock");
		x = xfers;
		wr(16'h4280, 8'h22, 16'h04d2, 1'b0);
		wr(16'h4280, 8'h22, 16'h04d2, 1'b0);
		chk(16'(xfers - x), 16'h0002, "xfers");
		chk(seen_data, 16'h04d2, "data");
		chk(seen_term, 16'h0003, "term");
		chk(seen_reg, 16'h0021, "reg");
		wr(16'h4280, 8'h20, 16'h0000, 1'b0);
		chk(user_commit, 16'h0001, "commit");
		chk(unlocked, 16'h0000, "lock");
	endtask
	task automatic t_pages;
		for (int n = 0; n < 8; n++) begin
			lat <= 4'(n);
			wr(16'h4280 + 16'(n), 8'h02, 16'(n), 1'b0);
			chk(seen_chan, 16'(n / 2), "chan");
			chk(seen_reg, (n % 2) ? 16'h0041 : 16'h0001, "reg");
		end
	endtask
	task automatic t_aborts;
		wr(16'h4288, 8'h01, 16'h0000, 1'b1);
		wr(16'h4280, 8'h00, 16'h0000, 1'b1);
		fail_en <= 1'b1;
		wr(16'h4280, 8'h05, 16'h0000, 1'b1);
		fail_en <= 1'b0;
		wr(16'h427f, 8'h00, 16'h0000, 1'b0);
		chk(term_sel, 16'h0000, "desel");
		wr(16'h4280, 8'h01, 16'h0000, 1'b1);
		wr(16'h427f, 8'h00, 16'h0005, 1'b0);
		wr(16'h4280, 8'h01, 16'h0000, 1'b1);
		wr(16'h427f, 8'h00, 16'h0002, 1'b0);
		wr(16'h4280, 8'h01, 16'h0000, 1'b1);
		wr(16'h427f, 8'h00, 16'h0001, 1'b0);
		wr(16'h4280, 8'h01, 16'h0000, 1'b0);
		chk(16'(commits), 16'h0001, "commits");
	endtask
	initial begin
		{rstn, req_valid, req_index, req_sub, req_data, fail_en} = '0;
		{term_count, term_regcap, lat} = {16'h0004, 64'hd, 4'h2};
		repeat (20) @(posedge core_clk);
		rstn <= 1'b1;
		t_code;
		t_pages;
		t_aborts;
		end_sim;
	end
endmodule // trg_gateway_bench
`default_nettype wire
